/* verilog/pac_pkg.sv */
// holds offsets, reset values, field positions and carrier types of the
// calibration, detector/pump and exact-frequency register slice.
// assumes a serial host port elsewhere decodes frames into word writes.
package pac_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [5:0] CAL_CFG_ADDR = 6'h0A;
	localparam logic [5:0] PUMP_CTL_ADDR = 6'h0B;
	localparam logic [5:0] EXACT_CNT_ADDR = 6'h0C;
	localparam int REG_W = 24;
	localparam logic [23:0] CAL_CFG_RST = 24'h002046;
	localparam logic [23:0] PUMP_CTL_RST = 24'h078061;
	localparam logic [23:0] EXACT_CNT_RST = 24'h000000;

	// ****************************************
	// field positions
	// ****************************************
	localparam int MEAS_LSB = 0;
	localparam int CAL_DIS_BIT = 11;
	localparam int CLK_SEL_LSB = 13;
	localparam int RELOCK_BIT = 17;
	localparam int POL_INV_BIT = 4;
	localparam int UP_EN_BIT = 5;
	localparam int DN_EN_BIT = 6;
	localparam int FORCE_UP_BIT = 9;
	localparam int FORCE_DN_BIT = 10;
	localparam int FORCE_MID_BIT = 11;

	// ****************************************
	// counts
	// ****************************************
	localparam logic [8:0] MEAS_CYC_0 = 9'h001;
	localparam logic [8:0] MEAS_CYC_1 = 9'h002;
	localparam logic [8:0] MEAS_CYC_2 = 9'h004;
	localparam logic [8:0] MEAS_CYC_3 = 9'h008;
	localparam logic [8:0] MEAS_CYC_4 = 9'h020;
	localparam logic [8:0] MEAS_CYC_5 = 9'h040;
	localparam logic [8:0] MEAS_CYC_6 = 9'h080;
	localparam logic [8:0] MEAS_CYC_7 = 9'h100;
	localparam logic [5:0] CAL_DIV_0 = 6'h01;
	localparam logic [5:0] CAL_DIV_1 = 6'h04;
	localparam logic [5:0] CAL_DIV_2 = 6'h10;
	localparam logic [5:0] CAL_DIV_3 = 6'h20;
	localparam logic [23:0] EXACT_MIN_VALID = 24'h000002;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic en;
		logic [5:0] addr;
		logic [23:0] data;
	} pac_wr_t;

	typedef struct packed {
		logic up;
		logic dn;
		logic mid;
	} pac_pump_t;

	typedef enum logic [1:0] {
		RL_IDLE = 2'b01,
		RL_DONE = 2'b10
	} pac_relock_t;

endpackage

/* verilog/pac_regs.sv */
// register slice for vco band calibration setup, phase detector / charge
// pump control and exact-frequency channel count.
// assumes writes and reads arrive from the serial host port on sys_clk_i,
// and that lock, detector and modulator signals are already on sys_clk_i.
`timescale 1ns/100ps

// Functional notes
// - measurement code selects 1..256 reference cycles
// - bit 11 set disables band calibration
// - clock select divides reference by 1,4,16,32
// - relock bit allows one retry per failure
// - bit 4 inverts detector polarity
// - bits 5,6 enable pump up and down
// - bit 9 forces up unless forced down
// - bit 10 forces down unless forced up
// - up/down force beats mid-rail force
// - exact count zero off, one invalid
// - exact mode only with modulator type B
module pac_regs (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// register port from the serial host decoder
	input wire pac_pkg::pac_wr_t wr_i,
	input wire logic [5:0] rd_addr_i,
	output logic [23:0] rd_data_o,
	// calibration engine
	output logic [8:0] meas_cycles_o,
	output logic cal_enable_o,
	output logic cal_tick_o,
	input wire logic lock_fail_i,
	output logic relock_req_o,
	// phase detector and charge pump
	input wire logic pd_up_raw_i,
	input wire logic pd_dn_raw_i,
	output pac_pkg::pac_pump_t pump_o,
	// sigma-delta modulator
	input wire logic mod_type_b_i,
	output logic [23:0] exact_freq_channel_count_o,
	output logic exact_freq_enable_o,
	output logic exact_freq_invalid_o
);

	// ****************************************
	// register storage
	// ****************************************
	logic [23:0] cal_cfg_reg;
	logic [23:0] pump_ctl_reg;
	logic [23:0] exact_cnt_reg;

	// whole-word writes; reserved bits kept as written, no side effect
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cal_cfg_reg <= pac_pkg::CAL_CFG_RST;
			pump_ctl_reg <= pac_pkg::PUMP_CTL_RST;
			exact_cnt_reg <= pac_pkg::EXACT_CNT_RST;
		end else if (wr_i.en) begin
			case (wr_i.addr)
				pac_pkg::CAL_CFG_ADDR: cal_cfg_reg <= wr_i.data;
				pac_pkg::PUMP_CTL_ADDR: pump_ctl_reg <= wr_i.data;
				pac_pkg::EXACT_CNT_ADDR: exact_cnt_reg <= wr_i.data;
				default: ;
			endcase
		end
	end

	// registered readback, unmapped addresses read zero
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= '0;
		end else begin
			case (rd_addr_i)
				pac_pkg::CAL_CFG_ADDR: rd_data_o <= cal_cfg_reg;
				pac_pkg::PUMP_CTL_ADDR: rd_data_o <= pump_ctl_reg;
				pac_pkg::EXACT_CNT_ADDR: rd_data_o <= exact_cnt_reg;
				default: rd_data_o <= '0;
			endcase
		end
	end

	// ****************************************
	// calibration setup
	// ****************************************
	logic [2:0] meas_code;
	logic [1:0] clk_sel;
	logic [8:0] meas_next;
	logic [5:0] div_next;
	assign meas_code = cal_cfg_reg[pac_pkg::MEAS_LSB +: 3];
	assign clk_sel = cal_cfg_reg[pac_pkg::CLK_SEL_LSB +: 2];

	// code to cycle count; note the jump from 8 to 32
	always_comb begin
		case (meas_code)
			3'h0: meas_next = pac_pkg::MEAS_CYC_0;
			3'h1: meas_next = pac_pkg::MEAS_CYC_1;
			3'h2: meas_next = pac_pkg::MEAS_CYC_2;
			3'h3: meas_next = pac_pkg::MEAS_CYC_3;
			3'h4: meas_next = pac_pkg::MEAS_CYC_4;
			3'h5: meas_next = pac_pkg::MEAS_CYC_5;
			3'h6: meas_next = pac_pkg::MEAS_CYC_6;
			default: meas_next = pac_pkg::MEAS_CYC_7;
		endcase
		case (clk_sel)
			2'h0: div_next = pac_pkg::CAL_DIV_0;
			2'h1: div_next = pac_pkg::CAL_DIV_1;
			2'h2: div_next = pac_pkg::CAL_DIV_2;
			default: div_next = pac_pkg::CAL_DIV_3;
		endcase
	end

	// measurement length and engine gate
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meas_cycles_o <= pac_pkg::MEAS_CYC_6;
			cal_enable_o <= 1'b0;
		end else begin
			meas_cycles_o <= meas_next;
			cal_enable_o <= !cal_cfg_reg[pac_pkg::CAL_DIS_BIT];
		end
	end

	// calibration clock as a tick train; a change of divider restarts the
	// count so no tick comes from a stale, longer terminal value
	logic [5:0] div_cnt_reg;
	logic [5:0] div_prev_reg;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt_reg <= '0;
			div_prev_reg <= pac_pkg::CAL_DIV_1;
			cal_tick_o <= 1'b0;
		end else begin
			div_prev_reg <= div_next;
			if (div_prev_reg != div_next || div_cnt_reg == div_next - 6'h01) begin
				div_cnt_reg <= '0;
			end else begin
				div_cnt_reg <= div_cnt_reg + 6'h01;
			end
			cal_tick_o <= (div_prev_reg == div_next) && (div_cnt_reg == div_next - 6'h01);
		end
	end

	// ****************************************
	// relock after lock loss
	// ****************************************
	pac_pkg::pac_relock_t relock_reg;
	// one request per failure; rearm only once lock is good again
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			relock_reg <= pac_pkg::RL_IDLE;
			relock_req_o <= 1'b0;
		end else begin
			relock_req_o <= 1'b0;
			case (relock_reg)
				pac_pkg::RL_IDLE: begin
					if (lock_fail_i) begin
						relock_reg <= pac_pkg::RL_DONE;
						relock_req_o <= cal_cfg_reg[pac_pkg::RELOCK_BIT];
					end
				end
				pac_pkg::RL_DONE: begin
					if (!lock_fail_i) begin
						relock_reg <= pac_pkg::RL_IDLE;
					end
				end
				default: relock_reg <= pac_pkg::RL_IDLE;
			endcase
		end
	end

	// ****************************************
	// detector and charge pump steering
	// ****************************************
	logic pol_inv;
	logic f_up;
	logic f_dn;
	pac_pkg::pac_pump_t pump_next;
	assign pol_inv = pump_ctl_reg[pac_pkg::POL_INV_BIT];
	assign f_up = pump_ctl_reg[pac_pkg::FORCE_UP_BIT];
	assign f_dn = pump_ctl_reg[pac_pkg::FORCE_DN_BIT];

	// polarity swap, then enables, then test forces; both forces set
	// cancel each other rather than shorting the pump
	always_comb begin
		pump_next.up = (pol_inv ? pd_dn_raw_i : pd_up_raw_i)
			&& pump_ctl_reg[pac_pkg::UP_EN_BIT];
		pump_next.dn = (pol_inv ? pd_up_raw_i : pd_dn_raw_i)
			&& pump_ctl_reg[pac_pkg::DN_EN_BIT];
		pump_next.mid = 1'b0;
		if (f_up && !f_dn) begin
			pump_next.up = 1'b1;
			pump_next.dn = 1'b0;
		end else if (f_dn && !f_up) begin
			pump_next.dn = 1'b1;
			pump_next.up = 1'b0;
		end else if (!f_up && !f_dn && pump_ctl_reg[pac_pkg::FORCE_MID_BIT]) begin
			pump_next.up = 1'b0;
			pump_next.dn = 1'b0;
			pump_next.mid = 1'b1;
		end
	end

	// registered pump command, so the pins never see a combinational glitch
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pump_o <= '0;
		end else begin
			pump_o <= pump_next;
		end
	end

	// ****************************************
	// exact frequency
	// ****************************************
	// count always passes through; enable only when valid and modulator is type b
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			exact_freq_channel_count_o <= '0;
			exact_freq_enable_o <= 1'b0;
			exact_freq_invalid_o <= 1'b0;
		end else begin
			exact_freq_channel_count_o <= exact_cnt_reg;
			exact_freq_enable_o <= (exact_cnt_reg >= pac_pkg::EXACT_MIN_VALID)
				&& mod_type_b_i;
			exact_freq_invalid_o <= (exact_cnt_reg == 24'h000001);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	// measurement decode; code 6 is also the value that reset leaves
	AST_MEAS_DEFAULT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(meas_code == 3'h6) |=> (meas_cycles_o == 9'h080)
		) else $error("code 6 not 128");
	AST_MEAS_MAP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(meas_code == 3'h4) |=> (meas_cycles_o == 9'h020)
		) else $error("code 4 not 32");
	AST_MEAS_LONGEST: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(meas_code == 3'h7) |=> (meas_cycles_o == 9'h100)
		) else $error("code 7 not 256");
	AST_MEAS_SHORTEST: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(meas_code == 3'h0) |=> (meas_cycles_o == 9'h001)
		) else $error("code 0 not 1");

	// engine gate follows the disable bit one edge later
	AST_CAL_GATE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		cal_cfg_reg[11] |=> !cal_enable_o
		) else $error("cal not disabled");
	AST_CAL_OPEN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!cal_cfg_reg[11] |=> cal_enable_o
		) else $error("cal not enabled");

	// tick spacing is only judged once the select has stood still, since
	// a select change may legally leave one stale tick behind
	AST_TICK_SPACING: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(cal_tick_o && clk_sel == 2'h1 && $past(clk_sel) == 2'h1
		&& $past(clk_sel, 2) == 2'h1 && $past(clk_sel, 3) == 2'h1
		&& $past(clk_sel, 4) == 2'h1)
		|-> (!$past(cal_tick_o) && !$past(cal_tick_o, 2) && !$past(cal_tick_o, 3))
		) else $error("div4 tick too soon");
	AST_TICK_DIV1: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(clk_sel == 2'h0) [*3] |=> cal_tick_o
		) else $error("div1 no tick");

	// relock: one request per failure episode, none when not armed
	AST_RELOCK_ONCE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(lock_fail_i && $past(lock_fail_i)) |=> !relock_req_o
		) else $error("second relock");
	AST_RELOCK_OFF: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!cal_cfg_reg[17]) |=> !relock_req_o
		) else $error("relock while off");
	AST_RELOCK_FIRE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(relock_reg == pac_pkg::RL_IDLE && lock_fail_i && cal_cfg_reg[17]) |=> relock_req_o
		) else $error("armed relock missing");

	// pump steering: forces, mid rail, polarity and enables
	AST_FORCE_UP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(f_up && !f_dn) |=> (pump_o.up && !pump_o.dn && !pump_o.mid)
		) else $error("force up wrong");
	AST_FORCE_DN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(f_dn && !f_up) |=> (pump_o.dn && !pump_o.up && !pump_o.mid)
		) else $error("force down wrong");
	AST_FORCE_MID: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!f_up && !f_dn && pump_ctl_reg[11]) |=> (pump_o.mid && !pump_o.up && !pump_o.dn)
		) else $error("mid rail not forced");
	AST_POLARITY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(pol_inv && !f_up && !f_dn && !pump_ctl_reg[11] && pump_ctl_reg[5] && pd_dn_raw_i)
		|=> pump_o.up
		) else $error("polarity not swapped");
	AST_UP_GATED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!f_up && !f_dn && !pump_ctl_reg[11] && !pump_ctl_reg[5]) |=> !pump_o.up
		) else $error("up not gated");
	AST_DN_GATED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!f_up && !f_dn && !pump_ctl_reg[11] && !pump_ctl_reg[6]) |=> !pump_o.dn
		) else $error("down not gated");

	// exact-frequency qualification and hand-over
	AST_EXACT_VALID: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(exact_cnt_reg < 24'h000002 || !mod_type_b_i) |=> !exact_freq_enable_o
		) else $error("exact mode enabled illegally");
	AST_EXACT_ON: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(exact_cnt_reg >= 24'h000002 && mod_type_b_i) |=> exact_freq_enable_o
		) else $error("exact mode not enabled");
	AST_EXACT_INVALID: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(exact_cnt_reg == 24'h000001) |=> exact_freq_invalid_o
		) else $error("count one not flagged");
	AST_EXACT_COPY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		1'b1 |=> (exact_freq_channel_count_o == $past(exact_cnt_reg))
		) else $error("count not handed over");

	// readback shows the stored word, reserved bits included
	AST_READBACK: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(rd_addr_i == pac_pkg::CAL_CFG_ADDR) |=> (rd_data_o == $past(cal_cfg_reg))
		) else $error("readback differs");

endmodule

/* test/pac_host_model.sv */
// host side model: serial-port decoder view that writes and reads words.
// assumes the bench calls its tasks and that sys_clk_i clocks the slice.
`timescale 1ns/100ps
module pac_host_model (
	// clock
	input wire logic sys_clk_i,
	// register port
	output pac_pkg::pac_wr_t wr_o,
	output logic [5:0] rd_addr_o,
	input wire logic [23:0] rd_data_i
);
	// ****************************************
	// host accesses
	// ****************************************
	initial begin
		wr_o = '0;
		rd_addr_o = 6'h00;
	end

	// one whole word per strobe; pump control bits 8:7 are cleared, other codes and counts come legal from the caller
	task automatic write_word(input logic [5:0] a, input logic [23:0] d);
		logic [23:0] w;
		w = d;
		if (a == pac_pkg::PUMP_CTL_ADDR) begin
			w[8:7] = 2'h0;
		end
		@(negedge sys_clk_i);
		wr_o <= '{en: 1'b1, addr: a, data: w};
		@(negedge sys_clk_i);
		wr_o.en <= 1'b0;
	endtask

	// read data lands on the same edge that samples the address
	task automatic read_word(input logic [5:0] a, output logic [23:0] d);
		@(negedge sys_clk_i);
		rd_addr_o <= a;
		repeat (2) @(negedge sys_clk_i);
		d = rd_data_i;
	endtask
endmodule

/* test/pac_regs_tb.sv */
// self-checking bench for the calibration, pump and exact-count slice.
// assumes the host model in the same folder and no outside stimulus.
`timescale 1ns/100ps
module pac_regs_tb;
	logic sys_clk_i, rst_n_i, cal_en, tick, lock_fail, relock, up_raw, dn_raw, type_b;
	pac_pkg::pac_wr_t wr;
	pac_pkg::pac_pump_t pump;
	logic [5:0] rd_addr;
	logic [23:0] rd_data, ex_cnt;
	logic [8:0] meas;
	logic ex_en, ex_inv;
	int err_count = 0;
	int tests_run = 0;

	pac_host_model i_host (.sys_clk_i(sys_clk_i), .wr_o(wr), .rd_addr_o(rd_addr),
		.rd_data_i(rd_data));
	pac_regs i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wr_i(wr), .rd_addr_i(rd_addr),
		.rd_data_o(rd_data), .meas_cycles_o(meas), .cal_enable_o(cal_en), .cal_tick_o(tick),
		.lock_fail_i(lock_fail), .relock_req_o(relock), .pd_up_raw_i(up_raw),
		.pd_dn_raw_i(dn_raw), .pump_o(pump), .mod_type_b_i(type_b),
		.exact_freq_channel_count_o(ex_cnt), .exact_freq_enable_o(ex_en),
		.exact_freq_invalid_o(ex_inv));

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// write then let register and derived outputs land
	task automatic wr_set(input logic [5:0] a, input logic [23:0] d);
		i_host.write_word(a, d);
		repeat (3) @(negedge sys_clk_i);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic test_reset();
		logic [23:0] d;
		i_host.read_word(pac_pkg::CAL_CFG_ADDR, d);
		chk("cal_cfg", 24'h002046, d);
		i_host.read_word(pac_pkg::PUMP_CTL_ADDR, d);
		chk("pump_ctl", 24'h078061, d);
		i_host.read_word(pac_pkg::EXACT_CNT_ADDR, d);
		chk("exact_cnt", 24'h000000, d);
		i_host.read_word(6'h0D, d);
		chk("unmapped", 24'h000000, d);
		chk("meas", 24'h000080, 24'(meas));
		chk("cal_en", 24'h000001, 24'(cal_en));
	endtask

	// a reset in mid-run must bring back every default, whatever was written
	task automatic test_rereset();
		logic [23:0] d;
		wr_set(pac_pkg::CAL_CFG_ADDR, 24'h03E803);
		wr_set(pac_pkg::PUMP_CTL_ADDR, 24'h000E10);
		wr_set(pac_pkg::EXACT_CNT_ADDR, 24'h000123);
		chk("ex_cnt", 24'h000123, ex_cnt);
		rst_n_i = 1'b0;
		repeat (5) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		chk("meas_rst", 24'h000080, 24'(meas));
		chk("ex_cnt_rst", 24'h000000, ex_cnt);
		i_host.read_word(pac_pkg::CAL_CFG_ADDR, d);
		chk("cal_cfg_rst", 24'h002046, d);
		i_host.read_word(pac_pkg::PUMP_CTL_ADDR, d);
		chk("pump_ctl_rst", 24'h078061, d);
		i_host.read_word(pac_pkg::EXACT_CNT_ADDR, d);
		chk("exact_cnt_rst", 24'h000000, d);
		chk("cal_en_rst", 24'h000001, 24'(cal_en));
	endtask

	task automatic test_meas();
		logic [8:0] t [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h020, 9'h040, 9'h080, 9'h100};
		logic [23:0] d;
		for (int i = 0; i < 8; i++) begin
			wr_set(pac_pkg::CAL_CFG_ADDR, 24'hFC1078 | 24'(i));
			chk("meas", 24'(t[i]), 24'(meas));
			i_host.read_word(pac_pkg::CAL_CFG_ADDR, d);
			chk("cal_rb", 24'hFC1078 | 24'(i), d);
		end
		wr_set(pac_pkg::CAL_CFG_ADDR, 24'h002846);
		chk("cal_en", 24'h000000, 24'(cal_en));
	endtask

	// tick count over a 64-cycle window once the divider has settled
	task automatic test_tick();
		int n;
		int div [4] = '{1, 4, 16, 32};
		for (int s = 0; s < 4; s++) begin
			wr_set(pac_pkg::CAL_CFG_ADDR, 24'h000006 | (24'(s) << 13));
			repeat (40) @(negedge sys_clk_i);
			n = 0;
			repeat (64) begin
				@(negedge sys_clk_i);
				n += int'(tick);
			end
			chk("ticks", 24'(64 / div[s]), 24'(n));
		end
	endtask

	// two failure episodes: one pulse each only when retry is armed
	task automatic test_relock();
		int n;
		for (int b = 0; b < 2; b++) begin
			wr_set(pac_pkg::CAL_CFG_ADDR, 24'h002046 | (24'(b) << 17));
			n = 0;
			repeat (2) begin
				lock_fail = 1'b1;
				repeat (6) begin
					@(negedge sys_clk_i);
					n += int'(relock);
				end
				lock_fail = 1'b0;
				repeat (3) @(negedge sys_clk_i);
			end
			chk("relock", 24'(2 * b), 24'(n));
		end
	endtask

	// rows: control word, raw up/down, expected up/down/mid
	task automatic test_pump();
		logic [23:0] w [9] = '{24'h078061, 24'h078071, 24'h078041, 24'h078021, 24'h078261,
			24'h078461, 24'h078661, 24'h078861, 24'h078A61};
		logic [1:0] r [9] = '{2'b10, 2'b10, 2'b10, 2'b01, 2'b01, 2'b10, 2'b01, 2'b00, 2'b00};
		logic [2:0] e [9] = '{3'b100, 3'b010, 3'b000, 3'b000, 3'b100, 3'b010, 3'b010, 3'b001,
			3'b100};
		for (int i = 0; i < 9; i++) begin
			{up_raw, dn_raw} = r[i];
			wr_set(pac_pkg::PUMP_CTL_ADDR, w[i]);
			chk("pump", 24'(e[i]), 24'(pump));
		end
		wr_set(pac_pkg::PUMP_CTL_ADDR, 24'h078061);
	endtask

	// nonzero count with another modulator type is a deliberate host slip
	task automatic test_exact();
		logic [23:0] v [4] = '{24'h000000, 24'h000001, 24'h000002, 24'hFFFFFF};
		for (int b = 0; b < 2; b++) begin
			type_b = b[0];
			for (int i = 0; i < 4; i++) begin
				wr_set(pac_pkg::EXACT_CNT_ADDR, v[i]);
				chk("ex_cnt", v[i], ex_cnt);
				chk("ex_en", 24'((v[i] > 24'h1) && b == 1), 24'(ex_en));
				chk("ex_inv", 24'(v[i] == 24'h1), 24'(ex_inv));
			end
		end
		wr_set(pac_pkg::EXACT_CNT_ADDR, 24'h000000);
	endtask

	// ****************************************
	// run
	// ****************************************
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// a hang counts as a mismatch and closes the run
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		err_count++;
		complete_run();
	end

	initial begin
		rst_n_i = 1'b0;
		{lock_fail, up_raw, dn_raw, type_b} = 4'h0;
		repeat (20) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		rst_n_i = 1'b1;
		test_reset();
		test_meas();
		test_tick();
		test_relock();
		test_pump();
		test_exact();
		test_rereset();
		complete_run();
	end
endmodule
